// ===== core/btzm_pkg.sv
// package for the battery temperature zone monitor
// assumes one 25 MHz system clock; voltages arrive as millivolt codes
package btzm_pkg;

	localparam int SENSE_W = 11;
	localparam int SYS_W = 13;
	localparam int CODE_W = 6;

	// temperature zone status codes
	localparam logic [2:0] ZONE_OFF = 3'h0;
	localparam logic [2:0] ZONE_COLD = 3'h1;
	localparam logic [2:0] ZONE_COOL = 3'h2;
	localparam logic [2:0] ZONE_NORMAL = 3'h3;
	localparam logic [2:0] ZONE_WARM = 3'h4;
	localparam logic [2:0] ZONE_HOT = 3'h5;

	// monitor channel select codes
	localparam logic [3:0] MUX_OFF = 4'h0;
	localparam logic [3:0] MUX_CH_SENSE = 4'h6;
	localparam logic [3:0] MUX_CH_BIAS = 4'h7;

	// charge voltage code scale and the system margin, in millivolts
	localparam logic [SYS_W-1:0] CV_BASE_MV = 13'hE10;
	localparam logic [SYS_W-1:0] CV_STEP_MV = 13'h019;
	localparam logic [SYS_W-1:0] SYS_MARGIN_MV = 13'h0C8;

	// charger state code shown while paused by temperature
	localparam logic [2:0] CHG_TEMP_FAULT = 3'h7;

	// twelve trip levels in millivolts, coldest first
	localparam logic [SENSE_W-1:0] TRIP_MV [12] = '{
		11'h400, 11'h3D0, 11'h39B, 11'h363, 11'h327, 11'h2EB,
		11'h1FF, 11'h1CB, 11'h19B, 11'h16F, 11'h147, 11'h123};

	// first trip level of each threshold: cold, cool, warm, hot
	localparam logic [3:0] TRIP_BASE [4] = '{4'h0, 4'h2, 4'h6, 4'h8};
	localparam int THR_COLD = 0;
	localparam int THR_COOL = 1;
	localparam int THR_WARM = 2;
	localparam int THR_HOT = 3;

	typedef struct packed {
		logic [1:0] hot;
		logic [1:0] warm;
		logic [1:0] cool;
		logic [1:0] cold;
	} btzm_thr_sel_t;

	typedef struct packed {
		logic [CODE_W-1:0] voltage;
		logic [CODE_W-1:0] current;
	} btzm_codes_t;

	typedef enum logic [0:0] {
		FS_RUN = 1'b0,
		FS_TEMP_FAULT = 1'b1
	} btzm_fault_state_t;

	function automatic logic [SYS_W-1:0] btzm_cv_to_mv(input logic [CODE_W-1:0] code);
		logic [SYS_W-1:0] prod;
		prod = SYS_W'(13'(code) * CV_STEP_MV);
		return SYS_W'(CV_BASE_MV + prod);
	endfunction : btzm_cv_to_mv

endpackage : btzm_pkg

// ===== core/btzm_zone_cmp.sv
// threshold comparators and zone classifier
// assumes the sense voltage code is synchronous and settled
`timescale 1ns/1ps
module btzm_zone_cmp
	import btzm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// sense and setup
	input wire logic [SENSE_W-1:0] sense_mv_in,
	input wire btzm_thr_sel_t thr_sel_in,
	input wire logic enable_in,
	// result
	output logic [2:0] zone_out
);

	logic [1:0] sel [4];
	logic [3:0] above;
	logic [2:0] next_zone;

	assign sel[THR_COLD] = thr_sel_in.cold;
	assign sel[THR_COOL] = thr_sel_in.cool;
	assign sel[THR_WARM] = thr_sel_in.warm;
	assign sel[THR_HOT] = thr_sel_in.hot;

	// ntc divider: a higher sense voltage means a colder battery
	for (genvar i = 0; i < 4; i++)
	begin : g_cmp
		logic [3:0] idx;
		assign idx = 4'(TRIP_BASE[i] + 4'(sel[i]));
		assign above[i] = sense_mv_in > TRIP_MV[idx];
	end

	always_comb
	begin
		if (!enable_in)
			next_zone = ZONE_OFF;
		else if (above[THR_COLD])
			next_zone = ZONE_COLD;
		else if (!above[THR_HOT])
			next_zone = ZONE_HOT;
		else if (above[THR_COOL])
			next_zone = ZONE_COOL;
		else if (!above[THR_WARM])
			next_zone = ZONE_WARM;
		else
			next_zone = ZONE_NORMAL;
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			zone_out <= ZONE_OFF;
		else
			zone_out <= next_zone;
	end

endmodule : btzm_zone_cmp

// ===== core/btzm_monitor.sv
// battery temperature zone monitor top
// assumes the partner charger reports its state and obeys pause and restart
//
// Overview of operation
// - system rail regulation starts once the charge input is valid.
// - charge voltage code steps down until system target exceeds it by 200mV.
// - each forced reduction sets the sticky configuration error flag.
// - zone comparators run continuously while thermistor enable is set.
// - normal zone uses the normal voltage and current codes.
// - cool or warm zone uses the separate 6-bit temperature-modified codes.
// - hot or cold zone pauses charging and enters temperature fault.
// - 3-bit zone status; any change sets a maskable flag.
// - thermistor enable low removes every temperature reaction.
// - each threshold picks one of four trip levels by a 2-bit field.
// - twelve trip levels from 1.024V down to 0.291V.
// - bias on while charge input valid and thermistor enabled.
// - bias on while the monitor selects the sense or bias node.
// - monitor channel choice never touches comparators or zone response.
// - timers pause in fault; on exit fast-charge and top-off restart.
// - on fault exit the charger returns to its state before the fault.
// - monitor channel select of zero disables the output buffer.
`timescale 1ns/1ps
module btzm_monitor
	import btzm_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// analog side
	input wire logic charge_input_valid_in,
	input wire logic [SENSE_W-1:0] sense_mv_in,
	input wire logic [SYS_W-1:0] sys_reg_mv_in,
	// configuration
	input wire logic thermistor_enable_in,
	input wire btzm_thr_sel_t thr_sel_in,
	input wire btzm_codes_t temp_mod_codes_in,
	input wire logic [CODE_W-1:0] normal_current_code_in,
	input wire logic cv_write_in,
	input wire logic [CODE_W-1:0] cv_write_data_in,
	input wire logic [3:0] monitor_channel_select_in,
	// flag control
	input wire logic zone_irq_mask_in,
	input wire logic zone_irq_clear_in,
	input wire logic cfg_irq_clear_in,
	// charger state machine
	input wire logic [2:0] charger_state_in,
	// status and flags
	output logic [2:0] temp_zone_status_out,
	output logic temp_zone_change_irq_out,
	output logic sys_config_error_irq_out,
	output logic charger_irq_out,
	output logic [CODE_W-1:0] charge_voltage_code_out,
	// charge control
	output btzm_codes_t active_codes_out,
	output logic charge_pause_out,
	output logic [2:0] charger_state_out,
	output logic [2:0] resume_state_out,
	output logic resume_pulse_out,
	output logic timers_pause_out,
	output logic fc_topoff_restart_out,
	// analog control
	output logic sys_reg_active_out,
	output logic bias_enable_out,
	output logic monitor_buffer_en_out
);

	////////////////////////////////////////////////////////////////////////////
	// zone classification
	logic [2:0] zone;

	// the monitor channel select is deliberately not wired in here
	btzm_zone_cmp i_btzm_zone_cmp (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.sense_mv_in(sense_mv_in),
		.thr_sel_in(thr_sel_in),
		.enable_in(thermistor_enable_in),
		.zone_out(zone)
	);

	logic fault_cond;
	logic mod_cond;
	assign fault_cond = thermistor_enable_in && (zone == ZONE_COLD || zone == ZONE_HOT);
	assign mod_cond = thermistor_enable_in && (zone == ZONE_COOL || zone == ZONE_WARM);

	////////////////////////////////////////////////////////////////////////////
	// temperature fault sequencing
	btzm_fault_state_t fstate;
	btzm_fault_state_t next_fstate;
	logic [2:0] saved_state;
	logic [2:0] next_saved_state;
	logic next_resume_pulse;
	logic next_restart;

	always_comb
	begin
		next_fstate = fstate;
		next_saved_state = saved_state;
		next_resume_pulse = 1'b0;
		next_restart = 1'b0;
		case (fstate)
			FS_RUN:
			begin
				if (fault_cond)
				begin
					next_fstate = FS_TEMP_FAULT;
					next_saved_state = charger_state_in;
				end
			end
			FS_TEMP_FAULT:
			begin
				if (!fault_cond)
				begin
					next_fstate = FS_RUN;
					next_resume_pulse = 1'b1;
					next_restart = 1'b1;
				end
			end
			default:
				next_fstate = FS_RUN;
		endcase
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			fstate <= FS_RUN;
			saved_state <= 3'h0;
			resume_pulse_out <= 1'b0;
			fc_topoff_restart_out <= 1'b0;
		end
		else
		begin
			fstate <= next_fstate;
			saved_state <= next_saved_state;
			resume_pulse_out <= next_resume_pulse;
			fc_topoff_restart_out <= next_restart;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// charge parameters and status outputs
	btzm_codes_t next_active_codes;
	logic [2:0] next_charger_state;
	logic next_zone_flag;
	logic next_cfg_flag;
	logic [CODE_W-1:0] next_cv;
	logic cv_short;

	assign cv_short = sys_reg_mv_in < SYS_W'(btzm_cv_to_mv(charge_voltage_code_out) + SYS_MARGIN_MV);

	always_comb
	begin
		if (mod_cond)
			next_active_codes = temp_mod_codes_in;
		else
			next_active_codes = '{voltage: charge_voltage_code_out,
				current: normal_current_code_in};
		next_charger_state = (next_fstate == FS_TEMP_FAULT) ? CHG_TEMP_FAULT : charger_state_in;
		// a new event wins over a clear in the same cycle
		next_zone_flag = temp_zone_change_irq_out && !zone_irq_clear_in;
		if (zone != temp_zone_status_out)
			next_zone_flag = 1'b1;
		next_cfg_flag = sys_config_error_irq_out && !cfg_irq_clear_in;
		next_cv = charge_voltage_code_out;
		if (cv_write_in)
			next_cv = cv_write_data_in;
		else if (cv_short && charge_voltage_code_out != 6'h00)
		begin
			// one step per cycle keeps the datapath free of a divider
			next_cv = CODE_W'(charge_voltage_code_out - 6'h01);
			next_cfg_flag = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			active_codes_out <= '0;
			charge_pause_out <= 1'b0;
			timers_pause_out <= 1'b0;
			charger_state_out <= 3'h0;
			resume_state_out <= 3'h0;
			temp_zone_status_out <= ZONE_OFF;
			temp_zone_change_irq_out <= 1'b0;
			sys_config_error_irq_out <= 1'b0;
			charger_irq_out <= 1'b0;
			charge_voltage_code_out <= 6'h00;
			sys_reg_active_out <= 1'b0;
			bias_enable_out <= 1'b0;
			monitor_buffer_en_out <= 1'b0;
		end
		else
		begin
			active_codes_out <= next_active_codes;
			charge_pause_out <= fault_cond;
			// prequalification resumes simply because pause drops; it is never restarted
			timers_pause_out <= fault_cond;
			charger_state_out <= next_charger_state;
			resume_state_out <= next_saved_state;
			temp_zone_status_out <= zone;
			temp_zone_change_irq_out <= next_zone_flag;
			sys_config_error_irq_out <= next_cfg_flag;
			charger_irq_out <= (next_zone_flag && !zone_irq_mask_in) || next_cfg_flag;
			charge_voltage_code_out <= next_cv;
			sys_reg_active_out <= charge_input_valid_in;
			bias_enable_out <= (charge_input_valid_in && thermistor_enable_in)
				|| monitor_channel_select_in == MUX_CH_SENSE
				|| monitor_channel_select_in == MUX_CH_BIAS;
			monitor_buffer_en_out <= monitor_channel_select_in != MUX_OFF;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_fault_seen;
		fault_cond && fstate == FS_RUN;
	endsequence

	sequence s_fault_gone;
		!fault_cond && fstate == FS_TEMP_FAULT;
	endsequence

	a_cv_step_down: assert property (
		!cv_write_in && cv_short && charge_voltage_code_out != 6'h00
		|=> charge_voltage_code_out == $past(charge_voltage_code_out) - 6'h01)
		else $error("charge voltage code not reduced");

	a_cfg_flag_set: assert property (
		!cv_write_in && cv_short && charge_voltage_code_out != 6'h00
		|=> sys_config_error_irq_out)
		else $error("configuration error flag not set");

	a_fault_enter: assert property (
		s_fault_seen |=> charger_state_out == CHG_TEMP_FAULT && charge_pause_out
		&& resume_state_out == $past(charger_state_in))
		else $error("temperature fault not entered");

	a_fault_return: assert property (
		s_fault_gone |=> resume_pulse_out && fc_topoff_restart_out
		&& resume_state_out == $past(saved_state) ##1 !resume_pulse_out)
		else $error("fault exit not signalled");

	a_zone_change_flag: assert property (
		zone != temp_zone_status_out |=> temp_zone_change_irq_out
		&& temp_zone_status_out == $past(zone))
		else $error("zone change flag missed");

	a_disable_clears: assert property (
		!thermistor_enable_in [*3] |-> !charge_pause_out && !timers_pause_out
		&& temp_zone_status_out == ZONE_OFF)
		else $error("temperature reaction while disabled");

	a_modified_codes: assert property (
		mod_cond |=> active_codes_out == $past(temp_mod_codes_in))
		else $error("modified codes not applied");

	a_bias_on: assert property (
		charge_input_valid_in && thermistor_enable_in |=> bias_enable_out)
		else $error("thermistor bias not enabled");

	a_buffer_off: assert property (
		monitor_channel_select_in == MUX_OFF |=> !monitor_buffer_en_out)
		else $error("monitor buffer left enabled");

endmodule : btzm_monitor

// ===== verification/btzm_charger_model.sv
// behavioural charger state machine facing the monitor
// assumes the monitor pauses it and hands back the state to resume
`timescale 1ns/1ps
module btzm_charger_model
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// control from bench and monitor
	input wire logic advance_in,
	input wire logic pause_in,
	input wire logic resume_pulse_in,
	input wire logic [2:0] resume_state_in,
	// state reported to the monitor
	output logic [2:0] state_out
);
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			state_out <= 3'h1;
		else if (resume_pulse_in)
			state_out <= resume_state_in;
		else if (advance_in && !pause_in)
			state_out <= state_out + 3'h1;
	end
endmodule : btzm_charger_model

// ===== verification/btzm_monitor_tb.sv
// self-checking bench for the temperature zone monitor
// assumes the charger model file is compiled first
`timescale 1ns/1ps
module btzm_monitor_tb;
	import btzm_pkg::*;
	logic sys_clk_in, rst_in, chg_ok, th_en, cv_wr, mask, zclr, cclr, adv;
	logic [SENSE_W-1:0] sense;
	logic [SYS_W-1:0] sys_mv;
	btzm_thr_sel_t thr;
	btzm_codes_t tm, act;
	logic [CODE_W-1:0] cur, cv_d, cv;
	logic [3:0] mux;
	logic [2:0] st_in, zone, st_out, res_st;
	logic zirq, cirq, irq, pause, res_p, tpause, rst_t, sys_act, bias, buf_en;
	int bad_count, total_checks;
	btzm_monitor i_btzm_monitor (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.charge_input_valid_in(chg_ok), .sense_mv_in(sense), .sys_reg_mv_in(sys_mv),
		.thermistor_enable_in(th_en), .thr_sel_in(thr), .temp_mod_codes_in(tm),
		.normal_current_code_in(cur), .cv_write_in(cv_wr), .cv_write_data_in(cv_d),
		.monitor_channel_select_in(mux), .zone_irq_mask_in(mask),
		.zone_irq_clear_in(zclr), .cfg_irq_clear_in(cclr), .charger_state_in(st_in),
		.temp_zone_status_out(zone), .temp_zone_change_irq_out(zirq),
		.sys_config_error_irq_out(cirq), .charger_irq_out(irq),
		.charge_voltage_code_out(cv), .active_codes_out(act), .charge_pause_out(pause),
		.charger_state_out(st_out), .resume_state_out(res_st), .resume_pulse_out(res_p),
		.timers_pause_out(tpause), .fc_topoff_restart_out(rst_t),
		.sys_reg_active_out(sys_act), .bias_enable_out(bias),
		.monitor_buffer_en_out(buf_en));
	btzm_charger_model i_btzm_charger_model (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.advance_in(adv), .pause_in(pause), .resume_pulse_in(res_p),
		.resume_state_in(res_st), .state_out(st_in));
	////////////////////////////////////////////////////////////////
	task automatic step(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask : step
	task automatic chk(input string nm, input logic [12:0] e, input logic [12:0] g);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic print_verdict;
		if (bad_count == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	task automatic pulse(ref logic s);
		step(1);
		s = 1'b1;
		step(1);
		s = 1'b0;
	endtask : pulse
	task automatic zone_case(input int mv, input logic [2:0] z, input logic p,
		input logic [11:0] codes);
		step(1);
		sense = SENSE_W'(mv);
		step(4);
		chk("zone", 13'(z), 13'(zone));
		chk("pause", 13'(p), 13'(pause));
		chk("codes", 13'(codes), 13'(act));
	endtask : zone_case
	////////////////////////////////////////////////////////////////
	// normal codes are the written charge voltage code with the normal current
	task automatic t_zones;
		logic [11:0] nc;
		nc = {6'h0A, 6'h20};
		mux = MUX_CH_SENSE;
		zone_case(1100, ZONE_COLD, 1'b1, nc);
		zone_case(1000, ZONE_COOL, 1'b0, tm);
		zone_case(700, ZONE_NORMAL, 1'b0, nc);
		zone_case(450, ZONE_WARM, 1'b0, tm);
		zone_case(400, ZONE_HOT, 1'b1, nc);
		thr = '{hot: 2'h3, warm: 2'h0, cool: 2'h0, cold: 2'h3};
		zone_case(900, ZONE_COLD, 1'b1, nc);
		zone_case(300, ZONE_WARM, 1'b0, tm);
		thr = '0;
		th_en = 1'b0;
		zone_case(1100, ZONE_OFF, 1'b0, nc);
		// return to a normal temperature first so re-enabling does not trip a stray fault
		sense = SENSE_W'(700);
		th_en = 1'b1;
		mux = MUX_OFF;
	endtask : t_zones
	task automatic t_irq;
		zone_case(700, ZONE_NORMAL, 1'b0, {6'h0A, 6'h20});
		pulse(zclr);
		step(2);
		chk("zflag clr", 13'h0, 13'(zirq));
		mask = 1'b1;
		zone_case(450, ZONE_WARM, 1'b0, tm);
		chk("zflag", 13'h1, 13'(zirq));
		chk("irq masked", 13'h0, 13'(irq));
		mask = 1'b0;
		step(3);
		chk("irq", 13'h1, 13'(irq));
	endtask : t_irq
	task automatic t_fault;
		int np, nr;
		pulse(adv);
		pulse(adv);
		zone_case(1100, ZONE_COLD, 1'b1, {6'h0A, 6'h20});
		chk("state fault", 13'(CHG_TEMP_FAULT), 13'(st_out));
		chk("resume st", 13'h3, 13'(res_st));
		chk("tpause", 13'h1, 13'(tpause));
		step(1);
		sense = SENSE_W'(700);
		np = 0;
		nr = 0;
		repeat (8)
		begin
			step(1);
			np += int'(res_p === 1'b1);
			nr += int'(rst_t === 1'b1);
		end
		chk("resume pulses", 13'h1, 13'(np));
		chk("restart pulses", 13'h1, 13'(nr));
		chk("state back", 13'h3, 13'(st_out));
		chk("tpause off", 13'h0, 13'(tpause));
	endtask : t_fault
	// sys 4700: largest code keeping 200mV margin is 36
	task automatic t_config;
		chk("cv kept", 13'h0A, 13'(cv));
		chk("no cfg", 13'h0, 13'(cirq));
		sys_mv = 13'h125C;
		cv_d = 6'h28;
		pulse(cv_wr);
		step(30);
		chk("cv forced", 13'h24, 13'(cv));
		chk("cfg flag", 13'h1, 13'(cirq));
		pulse(cclr);
		step(2);
		chk("cfg clr", 13'h0, 13'(cirq));
	endtask : t_config
	task automatic t_bias;
		step(3);
		chk("bias", 13'h1, 13'(bias));
		chk("sys reg", 13'h1, 13'(sys_act));
		th_en = 1'b0;
		step(3);
		chk("bias off", 13'h0, 13'(bias));
		chk("buf off", 13'h0, 13'(buf_en));
		chg_ok = 1'b0;
		for (int i = 6; i < 8; i++)
		begin
			mux = 4'(i);
			step(3);
			chk("bias mux", 13'h1, 13'(bias));
			chk("buf on", 13'h1, 13'(buf_en));
		end
		mux = MUX_OFF;
		step(3);
		chk("bias idle", 13'h0, 13'(bias));
		chk("sys reg off", 13'h0, 13'(sys_act));
	endtask : t_bias
	////////////////////////////////////////////////////////////////
	initial
	begin
		sys_clk_in = 1'b0;
		forever #20 sys_clk_in = ~sys_clk_in;
	end
	initial
	begin
		#400000;
		bad_count++;
		print_verdict();
	end
	initial
	begin
		bad_count = 0;
		total_checks = 0;
		rst_in = 1'b1;
		{chg_ok, th_en, cv_wr, mask, zclr, cclr, adv} = 7'h00;
		sense = SENSE_W'(700);
		sys_mv = 13'h1F40;
		thr = '0;
		tm = {6'h05, 6'h07};
		cur = 6'h20;
		cv_d = 6'h0A;
		mux = MUX_OFF;
		step(3);
		rst_in = 1'b0;
		chk("reset zone", 13'(ZONE_OFF), 13'(zone));
		chk("reset cv", 13'h0, 13'(cv));
		pulse(cv_wr);
		chg_ok = 1'b1;
		th_en = 1'b1;
		t_zones();
		t_irq();
		t_fault();
		t_config();
		t_bias();
		print_verdict();
	end
endmodule : btzm_monitor_tb
